// ==== inc/smb_client_pkg.sv ====
// constants and carrier types for the two-wire client register port
// Functional notes
// R1 - first byte: seven-bit address plus direction
// R2 - client address from sixteen-level strap
// R3 - strap also sets enable polarity, mirrored
// R4 - bytes eight bits, msb first
// R5 - client acks every received byte
// R6 - host nacks last read byte
// R7 - stop resets client state machine
// R8 - low clock timeout resets protocol logic
// R9 - idle high resets unless sleeping
// R10 - timeouts disabled until bit cleared
// R11 - after timeout resume at next start
// R12 - works from 10 to 400 kHz
// R13 - block transfers unlimited, no count byte
// R14 - write byte stores data at pointer
// R15 - read byte uses repeated start
// R16 - address-only write just loads pointer
// R17 - read without address uses pointer
// R18 - block reads and writes supported
// R19 - pointer increments per byte, wraps
// R20 - start is data falling, clock high
// R21 - never stretch the clock
// R22 - wrong address ignored until start
// R23 - repeated start keeps the pointer
package smb_client_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned TIMEOUT_MS = 30;
    localparam int unsigned IDLE_US = 200;
    // longest times round down
    localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int unsigned IDLE_CYC = IDLE_US * CLK_MHZ;
    localparam int unsigned BYTE_BITS = 8;
    localparam logic [3:0] STRAP_HALF_BIT = 4'h8;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] PTR_STEP = 8'h01;

    typedef enum {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_PTR,
        ST_WACK,
        ST_WDATA,
        ST_RDATA,
        ST_RACK,
        ST_IGNORE
    } client_state_t;

    // register file access from the port
    typedef struct packed {
        logic wr_strobe;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // strap decode result
    typedef struct packed {
        logic [6:0] addr;
        logic active_high;
    } strap_cfg_t;

    // sixteen strap levels to address and polarity, upper half mirrored
    function automatic strap_cfg_t strap_decode(input logic [3:0] lvl);
        strap_cfg_t c;
        logic [2:0] k;
        c.active_high = lvl[3];
        k = lvl[3] ? ~lvl[2:0] : lvl[2:0];
        case (k)
            3'h0: c.addr = 7'h57;
            3'h1: c.addr = 7'h56;
            3'h2: c.addr = 7'h55;
            3'h3: c.addr = 7'h54;
            3'h4: c.addr = 7'h30;
            3'h5: c.addr = 7'h31;
            3'h6: c.addr = 7'h32;
            default: c.addr = 7'h33;
        endcase
        return c;
    endfunction
endpackage

// ==== core/smb_client_port.sv ====
// two-wire client port reaching an eight-bit register space
module smb_client_port
    import smb_client_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
    parameter int unsigned IDLE_CYCLES = IDLE_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic scl_out,
    output logic scl_oe,
    input wire logic [3:0] strap_level,
    input wire logic timeout_disable_bit,
    input wire logic sleep_state,
    output reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    output logic [6:0] client_addr,
    output logic port_power_enable_active_high,
    output logic busy
);

    // R12 sampling rate ample
    // three-stage synchronisers, first stage feeds only the second
    logic [2:0] scl_sync_reg, scl_sync_next;
    logic [2:0] sda_sync_reg, sda_sync_next;
    logic scl_reg, scl_next;
    logic sda_reg, sda_next;

    always_comb begin
        scl_sync_next = {scl_sync_reg[1:0], scl_in};
        sda_sync_next = {sda_sync_reg[1:0], sda_in};
        // a change counts only once stages two and three agree
        scl_next = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_reg;
        sda_next = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_reg;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end else begin
            scl_sync_reg <= scl_sync_next;
            sda_sync_reg <= sda_sync_next;
            scl_reg <= scl_next;
            sda_reg <= sda_next;
        end
    end

    // bus events from filtered levels
    logic scl_rise, scl_fall, start_ev, stop_ev;
    assign scl_rise = scl_next & ~scl_reg;
    assign scl_fall = ~scl_next & scl_reg;
    // R20 start detect
    assign start_ev = scl_reg & scl_next & sda_reg & ~sda_next;
    // R7 stop detect
    assign stop_ev = scl_reg & scl_next & ~sda_reg & sda_next;

    // strap capture one clock after reset release, strap treated as static
    logic strap_done_reg, strap_done_next;
    strap_cfg_t cfg_reg, cfg_next;

    always_comb begin
        strap_done_next = 1'b1;
        cfg_next = cfg_reg;
        // R2 R3 strap decode
        if (!strap_done_reg) begin
            cfg_next = strap_decode(strap_level);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            strap_done_reg <= 1'b0;
            cfg_reg <= '0;
        end else begin
            strap_done_reg <= strap_done_next;
            cfg_reg <= cfg_next;
        end
    end

    // bus watchdog counters
    logic [31:0] low_cnt_reg, low_cnt_next;
    logic [31:0] idle_cnt_reg, idle_cnt_next;
    logic wd_reset;

    always_comb begin
        low_cnt_next = 32'h0000_0000;
        idle_cnt_next = 32'h0000_0000;
        if (!scl_reg && low_cnt_reg <= TIMEOUT_CYCLES) begin
            low_cnt_next = low_cnt_reg + 32'h0000_0001;
        end
        if (scl_reg && sda_reg && idle_cnt_reg <= IDLE_CYCLES) begin
            idle_cnt_next = idle_cnt_reg + 32'h0000_0001;
        end
    end

    // R8 R9 R10 watchdog reset gated by disable bit, idle reset also by sleep
    assign wd_reset = !timeout_disable_bit &&
        ((low_cnt_reg > TIMEOUT_CYCLES) || (!sleep_state && idle_cnt_reg > IDLE_CYCLES));

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            low_cnt_reg <= 32'h0000_0000;
            idle_cnt_reg <= 32'h0000_0000;
        end else begin
            low_cnt_reg <= low_cnt_next;
            idle_cnt_reg <= idle_cnt_next;
        end
    end

    // protocol engine
    client_state_t state_reg, state_next;
    logic [7:0] shift_reg, shift_next;
    logic [2:0] bit_reg, bit_next;
    logic [7:0] ptr_reg, ptr_next;
    logic sda_drv_reg, sda_drv_next;
    reg_req_t req_reg, req_next;
    logic busy_next;
    // the clock fall that closes a start is not a data bit; only falls after a rise count
    logic armed_reg, armed_next;

    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        bit_next = bit_reg;
        ptr_next = ptr_reg;
        sda_drv_next = sda_drv_reg;
        req_next = req_reg;
        req_next.wr_strobe = 1'b0;
        armed_next = armed_reg;
        case (state_reg)
            ST_IDLE: begin
                sda_drv_next = 1'b0;
            end
            ST_ADDR, ST_PTR, ST_WDATA: begin
                // R4 msb-first shift on rising clock
                if (scl_rise) begin
                    shift_next = {shift_reg[6:0], sda_reg};
                    armed_next = 1'b1;
                end
                if (scl_fall && armed_reg) begin
                    bit_next = bit_reg + 3'h1;
                    if (bit_reg == BIT_LAST) begin
                        if (state_reg == ST_ADDR) begin
                            // R1 R22 address match, mismatch ignored until start
                            if (shift_reg[7:1] == cfg_reg.addr) begin
                                sda_drv_next = 1'b1;
                                state_next = ST_ADDR_ACK;
                            end else begin
                                state_next = ST_IGNORE;
                            end
                        end else if (state_reg == ST_PTR) begin
                            // R5 R16 ack the pointer byte, pointer loaded only
                            sda_drv_next = 1'b1;
                            ptr_next = shift_reg;
                            state_next = ST_WACK;
                        end else begin
                            // R5 R14 R18 ack data, store at pointer
                            sda_drv_next = 1'b1;
                            req_next.wr_strobe = 1'b1;
                            req_next.addr = ptr_reg;
                            req_next.wdata = shift_reg;
                            // R19 R13 advance with wrap, no count byte
                            ptr_next = ptr_reg + PTR_STEP;
                            state_next = ST_WACK;
                        end
                    end
                end
            end
            ST_ADDR_ACK: begin
                if (scl_fall) begin
                    bit_next = 3'h0;
                    // R15 R17 read takes reg_rdata as given; the pointer is not driven out for reads
                    if (shift_reg[0]) begin
                        shift_next = reg_rdata;
                        sda_drv_next = ~reg_rdata[7];
                        state_next = ST_RDATA;
                    end else begin
                        sda_drv_next = 1'b0;
                        state_next = ST_PTR;
                    end
                end
            end
            ST_WACK: begin
                if (scl_fall) begin
                    sda_drv_next = 1'b0;
                    bit_next = 3'h0;
                    state_next = ST_WDATA;
                end
            end
            ST_RDATA: begin
                if (scl_fall) begin
                    bit_next = bit_reg + 3'h1;
                    if (bit_reg == BIT_LAST) begin
                        // release for host ack, step pointer
                        sda_drv_next = 1'b0;
                        ptr_next = ptr_reg + PTR_STEP;
                        state_next = ST_RACK;
                    end else begin
                        shift_next = {shift_reg[6:0], 1'b0};
                        sda_drv_next = ~shift_reg[6];
                    end
                end
            end
            ST_RACK: begin
                if (scl_rise) begin
                    shift_next[0] = sda_reg;
                end
                if (scl_fall) begin
                    bit_next = 3'h0;
                    // R6 host nack ends the read; wait for stop or start
                    if (shift_reg[0]) begin
                        state_next = ST_IGNORE;
                    end else begin
                        shift_next = reg_rdata;
                        sda_drv_next = ~reg_rdata[7];
                        state_next = ST_RDATA;
                    end
                end
            end
            ST_IGNORE: begin
                sda_drv_next = 1'b0;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // R20 R23 start or repeated start restarts framing, pointer kept
        if (start_ev) begin
            state_next = ST_ADDR;
            bit_next = 3'h0;
            armed_next = 1'b0;
            sda_drv_next = 1'b0;
        end
        // R7 R11 stop or watchdog returns to idle, waits for next start
        if (stop_ev || wd_reset) begin
            state_next = ST_IDLE;
            sda_drv_next = 1'b0;
        end
        busy_next = (state_next != ST_IDLE) && (state_next != ST_IGNORE);
    end

    // pointer survives stops so later reads use it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
            shift_reg <= 8'h00;
            bit_reg <= 3'h0;
            ptr_reg <= PTR_RESET;
            sda_drv_reg <= 1'b0;
            req_reg <= '0;
            armed_reg <= 1'b0;
            busy <= 1'b0;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            bit_reg <= bit_next;
            ptr_reg <= ptr_next;
            sda_drv_reg <= sda_drv_next;
            req_reg <= req_next;
            armed_reg <= armed_next;
            busy <= busy_next;
        end
    end

    // open-drain data: output always low, enable pulls
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            scl_out <= 1'b0;
            scl_oe <= 1'b0;
            client_addr <= 7'h00;
            port_power_enable_active_high <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            sda_oe <= sda_drv_next;
            scl_out <= 1'b0;
            // R21 clock line never held
            scl_oe <= 1'b0;
            client_addr <= cfg_reg.addr;
            port_power_enable_active_high <= cfg_reg.active_high;
        end
    end

    assign reg_req = req_reg;

endmodule

// ==== testbench/smb_client_port_checker.sv ====
// assertions on the client port pins and register write requests
module smb_client_port_checker
    import smb_client_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
    parameter int unsigned IDLE_CYCLES = IDLE_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic [3:0] strap_level,
    input wire logic timeout_disable_bit,
    input wire logic sleep_state,
    input wire reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic [6:0] client_addr,
    input wire logic port_power_enable_active_high,
    input wire logic busy
);
    logic [31:0] low_cnt_reg;
    logic [31:0] low_cnt_next;
    logic [31:0] high_cnt_reg;
    logic [31:0] high_cnt_next;
    logic [7:0] last_addr_reg;
    logic [7:0] last_addr_next;
    logic seen_reg;
    logic seen_next;

    // quiet-bus counters saturate past the limit so the check keeps looking
    always_comb begin
        low_cnt_next = low_cnt_reg + 32'(low_cnt_reg < TIMEOUT_CYCLES + 20);
        high_cnt_next = high_cnt_reg + 32'(high_cnt_reg < IDLE_CYCLES + 20);
        if (scl_in || timeout_disable_bit)
            low_cnt_next = '0;
        if (!(scl_in && sda_in) || timeout_disable_bit || sleep_state)
            high_cnt_next = '0;
        seen_next = busy && (seen_reg || reg_req.wr_strobe);
        last_addr_next = reg_req.wr_strobe ? reg_req.addr : last_addr_reg;
    end

    // helper state registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            low_cnt_reg <= '0;
            high_cnt_reg <= '0;
            last_addr_reg <= '0;
            seen_reg <= 1'b0;
        end else begin
            low_cnt_reg <= low_cnt_next;
            high_cnt_reg <= high_cnt_next;
            last_addr_reg <= last_addr_next;
            seen_reg <= seen_next;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence s_stop;
        scl_in && $rose(sda_in);
    endsequence
    sequence s_strobe;
        reg_req.wr_strobe;
    endsequence

    property p_no_stretch;
        !scl_oe && !scl_out;
    endproperty
    a_no_stretch: assert property (p_no_stretch) else $error("client drove the clock line");
    property p_oe_low_clock;
        $changed(sda_oe) |-> !scl_in;
    endproperty
    a_oe_low_clock: assert property (p_oe_low_clock) else $error("data moved while clock high");
    property p_oe_addressed;
        $rose(sda_oe) |-> ##[0:4] busy;
    endproperty
    a_oe_addressed: assert property (p_oe_addressed) else $error("data pulled while not addressed");
    property p_strobe_pulse;
        s_strobe |=> !reg_req.wr_strobe;
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("write strobe longer than a cycle");
    property p_strobe_busy;
        s_strobe |-> busy;
    endproperty
    a_strobe_busy: assert property (p_strobe_busy) else $error("write outside a transaction");
    property p_addr_step;
        seen_reg && reg_req.wr_strobe |-> reg_req.addr == 8'(last_addr_reg + 8'h01);
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("block write address did not step");
    property p_cfg_stable;
        busy |-> $stable(client_addr) && $stable(port_power_enable_active_high);
    endproperty
    a_cfg_stable: assert property (p_cfg_stable) else $error("strap result moved in traffic");
    property p_stop;
        s_stop |-> ##[1:16] !busy;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not end transaction");
    property p_timeout;
        low_cnt_reg == TIMEOUT_CYCLES + 20 |-> !busy;
    endproperty
    a_timeout: assert property (p_timeout) else $error("low clock did not reset port");
    property p_idle;
        high_cnt_reg == IDLE_CYCLES + 20 |-> !busy;
    endproperty
    a_idle: assert property (p_idle) else $error("idle bus did not reset port");
endmodule

bind smb_client_port smb_client_port_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES), .IDLE_CYCLES(IDLE_CYCLES)) chk (
    .sys_clk(sys_clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .scl_out(scl_out), .scl_oe(scl_oe), .strap_level(strap_level), .timeout_disable_bit(timeout_disable_bit),
    .sleep_state(sleep_state), .reg_req(reg_req), .reg_rdata(reg_rdata), .client_addr(client_addr),
    .port_power_enable_active_high(port_power_enable_active_high), .busy(busy));

// ==== testbench/smb_host_model.sv ====
// host model: drives the two-wire bus as an open-drain controller
module smb_host_model (
    input wire logic scl_line,
    input wire logic sda_line,
    output logic scl_drv,
    output logic sda_drv
);
    timeunit 1ns;
    timeprecision 1ps;
    // quarter of a bit in ns; data bits move only mid-low, start and stop mid-high, to keep clear of the filter
    localparam int Q = 24;
    event rd_bit8;
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    // start: data falls while clock is high
    task automatic start();
        #Q;
        sda_drv = 1'b1;
        #Q;
        scl_drv = 1'b1;
        #(2 * Q);
        sda_drv = 1'b0;
        #(2 * Q);
        scl_drv = 1'b0;
    endtask
    // stop: data rises while clock is high
    task automatic stop();
        #Q;
        sda_drv = 1'b0;
        #Q;
        scl_drv = 1'b1;
        #(2 * Q);
        sda_drv = 1'b1;
        #(2 * Q);
    endtask
    // one clock: data set while low, line sampled mid-high
    task automatic bit_cyc(input logic b, output logic s);
        #Q;
        sda_drv = b;
        #Q;
        scl_drv = 1'b1;
        #Q;
        s = sda_line;
        #Q;
        scl_drv = 1'b0;
    endtask
    // eight bits, most significant first; ninth clock reads the answer
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_cyc(d[i], s);
        bit_cyc(1'b1, s);
        ack = !s;
    endtask
    // host acks every byte but the last, which it leaves high
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_cyc(1'b1, d[i]);
        ->rd_bit8;
        bit_cyc(last, s);
    endtask
endmodule

// ==== testbench/smb_client_port_tb.sv ====
// self-checking bench for the two-wire client port
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module smb_client_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import smb_client_pkg::*;
    logic sys_clk;
    logic rstn;
    logic scl_drv, sda_drv, scl_line, sda_line, sda_out, sda_oe, scl_out, scl_oe;
    logic [3:0] strap_level;
    logic timeout_disable_bit, sleep_state, pol, busy;
    reg_req_t reg_req;
    logic [7:0] reg_rdata, ptr;
    logic [6:0] client_addr, me;
    logic [7:0] mem [256];
    logic [7:0] mdl [256];
    logic [15:0] exp_q [$];
    int check_count = 0;
    int fail_count = 0;
    logic [6:0] atab [8] = '{7'h57, 7'h56, 7'h55, 7'h54, 7'h30, 7'h31, 7'h32, 7'h33};

    // open-drain lines with pull-ups; register file answers at the tracked pointer
    assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
    assign scl_line = scl_drv & ~(scl_oe & ~scl_out);
    assign reg_rdata = mem[ptr];

    smb_client_port #(.TIMEOUT_CYCLES(200), .IDLE_CYCLES(100)) dut (
        .sys_clk(sys_clk), .rstn(rstn), .scl_in(scl_line), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe), .strap_level(strap_level),
        .timeout_disable_bit(timeout_disable_bit), .sleep_state(sleep_state), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .client_addr(client_addr), .port_power_enable_active_high(pol), .busy(busy));
    smb_host_model host (.scl_line(scl_line), .sda_line(sda_line), .scl_drv(scl_drv), .sda_drv(sda_drv));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // read data is taken on the host ack clock, so the pointer moves after bit eight
    always @(host.rd_bit8) ptr = ptr + 8'h01;
    // every write strobe must match the oldest noted write
    always @(posedge sys_clk) begin
        if (rstn && reg_req.wr_strobe === 1'b1) begin
            mem[reg_req.addr] <= reg_req.wdata;
            if (exp_q.size() == 0) `CHK("stray write", 1'b0, 1'b1)
            else `CHK("write", exp_q.pop_front(), {reg_req.addr, reg_req.wdata})
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic reset_to(input logic [3:0] l);
        @(negedge sys_clk);
        rstn = 1'b0;
        strap_level = l;
        ptr = 8'h00;
        repeat (5) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (4) @(negedge sys_clk);
        me = atab[l[3] ? ~l[2:0] : l[2:0]];
        `CHK("client address", me, client_addr)
        `CHK("enable polarity", l[3], pol)
    endtask
    task automatic sb(input logic [7:0] b, input logic exp_ack);
        logic a;
        host.wbyte(b, a);
        `CHK("ack", exp_ack, a)
    endtask
    task automatic finish_xfer();
        host.stop();
        repeat (16) @(negedge sys_clk);
        `CHK("busy after stop", 1'b0, busy)
    endtask
    task automatic wr(input logic [7:0] p, input int n);
        logic [7:0] d;
        host.start();
        sb({me, 1'b0}, 1'b1);
        sb(p, 1'b1);
        ptr = p;
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            exp_q.push_back({ptr, d});
            mdl[ptr] = d;
            sb(d, 1'b1);
            ptr = ptr + 8'h01;
        end
        finish_xfer();
    endtask
    task automatic rd(input logic ptr_phase, input logic [7:0] p, input int n);
        logic [7:0] d;
        logic [7:0] e;
        host.start();
        if (ptr_phase) begin
            sb({me, 1'b0}, 1'b1);
            sb(p, 1'b1);
            ptr = p;
            host.start();
        end
        sb({me, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++) begin
            e = mdl[ptr];
            host.rbyte(i == n - 1, d);
            `CHK("read", e, d)
        end
        finish_xfer();
    endtask
    task automatic hold(input logic dis);
        @(negedge sys_clk);
        timeout_disable_bit = dis;
        host.start();
        sb({me, 1'b0}, 1'b1);
        #1000;
        `CHK("busy after long low clock", dis, busy)
        sb(8'h30, dis);
        finish_xfer();
    endtask

    initial begin
        rstn = 1'b0;
        strap_level = 4'h0;
        timeout_disable_bit = 1'b1;
        sleep_state = 1'b0;
        ptr = 8'h00;
        void'($urandom(32'h963b));
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'($urandom);
            mdl[i] = mem[i];
        end
        for (int l = 0; l < 16; l++)
            reset_to(4'(l));
        reset_to(4'($urandom));
        wr(8'h10, 1);
        // block write past the top register
        wr(8'hfe, 3);
        // pointer-only write, then read with no address phase
        wr(8'h42, 0);
        rd(1'b0, 8'h00, 1);
        // read byte, then block read through the wrap
        rd(1'b1, 8'h10, 1);
        rd(1'b1, 8'hfe, 4);
        host.start();
        sb({me ^ 7'h01, 1'b0}, 1'b0);
        sb(8'h20, 1'b0);
        finish_xfer();
        // stuck clock with watchdog off, then on
        hold(1'b1);
        hold(1'b0);
        wr(8'h30, 2);
        repeat (200) @(negedge sys_clk);
        `CHK("pending writes", 0, exp_q.size())
        stop_test();
    end
    initial begin
        #200us;
        fail_count++;
        stop_test();
    end
endmodule
